// ===== rtl/ubf_params.svh
// Constants for the break-field control block
`ifndef UBF_PARAMS_SVH
`define UBF_PARAMS_SVH
`define UBF_CTRL_RX_TRIG_BIT   6
`define UBF_CTRL_TX_TRIG_BIT   5
`define UBF_MODE_POWER_BIT     7
`define UBF_MODE_TXE_BIT       6
`define UBF_MODE_RXE_BIT       5
`define UBF_BAUD_DIV           2
`define UBF_CTRL_RESET         8'h00
`define UBF_MODE_RESET         8'h00
`define UBF_DIV_RESET          8'h00
`endif

// ===== rtl/ubf_pkg.sv
// Types for the break-field control block
package ubf_pkg;
    typedef enum logic [2:0] {
        UBF_IDLE = 3'b001,
        UBF_RX   = 3'b010,
        UBF_TX   = 3'b100
    } ubf_state_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] data;
    } ubf_wr_t;

    typedef struct packed {
        logic done;
        logic error;
    } ubf_evt_t;
endpackage

// ===== rtl/ubf_baud_div.sv
// Baud clock enable: 8-bit divider counter output divided by two
`timescale 1ns/100ps
`include "ubf_params.svh"
module ubf_baud_div
    import ubf_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       run,
    input  wire logic [7:0] divisor,
    output logic            baud_tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       half;
        logic       tick;
    } ubf_div_state_t;

    ubf_div_state_t div_reg;
    ubf_div_state_t div_next;

    always_comb begin
        div_next      = div_reg;
        div_next.tick = 1'b0;
        if (!run) begin
            div_next.cnt  = `UBF_DIV_RESET;
            div_next.half = 1'b0;
        end else if (div_reg.cnt >= divisor) begin
            div_next.cnt  = `UBF_DIV_RESET;
            // Counter output toggles the halving stage
            div_next.half = ~div_reg.half;
            div_next.tick = div_reg.half;
        end else begin
            div_next.cnt = div_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign baud_tick = div_reg.tick;
endmodule // ubf_baud_div

// ===== rtl/ubf_break_ctrl.sv
// Break-field trigger control with baud clock derivation
// Operation
// - Reading the receive trigger bit always returns zero.
// - Trigger bit clears on completion, same cycle as the interrupt pulse.
// - Reception error sets the error flag and holds it at one until an RX trigger is rewritten while operating.
// - Baud clock is the 8-bit divider output divided by two.
// - Rewriting a trigger bit while operating starts a new operation.
`timescale 1ns/100ps
`include "ubf_params.svh"
module ubf_break_ctrl
    import ubf_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  ubf_wr_t         ctrl_wr,
    input  ubf_wr_t         mode_wr,
    input  wire logic [7:0] divisor,
    input  ubf_evt_t        link_evt,
    output logic [7:0]      ctrl_rdata,
    output logic [7:0]      mode_rdata,
    output logic            break_rx_error_flag,
    output logic            break_busy,
    output logic            baud_tick,
    output logic            done_irq
);
    typedef struct packed {
        ubf_state_t st;
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic       err;
        logic       irq;
    } ubf_core_t;

    ubf_core_t core_reg;
    ubf_core_t core_next;
    logic      powered;
    logic      operating;

    assign powered   = core_reg.mode[`UBF_MODE_POWER_BIT];
    assign operating = powered && (core_reg.mode[`UBF_MODE_TXE_BIT]
                                || core_reg.mode[`UBF_MODE_RXE_BIT]);

    ubf_baud_div u_div (
        .clock     (clock),
        .nrst      (nrst),
        .run       (powered),
        .divisor   (divisor),
        .baud_tick (baud_tick)
    );

    always_comb begin
        core_next     = core_reg;
        core_next.irq = 1'b0;
        if (mode_wr.wr) begin
            core_next.mode = mode_wr.data;
        end
        unique case (core_reg.st)
            UBF_IDLE: ;
            UBF_RX: begin
                if (link_evt.error) begin
                    // Flag stays set until software re-arms
                    core_next.err = 1'b1;
                    core_next.st  = UBF_IDLE;
                    core_next.ctrl[`UBF_CTRL_RX_TRIG_BIT] = 1'b0;
                end else if (link_evt.done) begin
                    core_next.ctrl[`UBF_CTRL_RX_TRIG_BIT] = 1'b0;
                    core_next.irq = 1'b1;
                    core_next.st  = UBF_IDLE;
                end
            end
            UBF_TX: begin
                if (link_evt.done) begin
                    core_next.ctrl[`UBF_CTRL_TX_TRIG_BIT] = 1'b0;
                    core_next.irq = 1'b1;
                    core_next.st  = UBF_IDLE;
                end
            end
        endcase
        // A written trigger restarts whenever operating; refresh writes are not filtered
        if (ctrl_wr.wr) begin
            core_next.ctrl = ctrl_wr.data;
            if (operating && ctrl_wr.data[`UBF_CTRL_RX_TRIG_BIT]) begin
                core_next.st  = UBF_RX;
                core_next.err = 1'b0;
            end else if (operating && ctrl_wr.data[`UBF_CTRL_TX_TRIG_BIT]) begin
                core_next.st = UBF_TX;
            end
        end
        // Triggers only take effect with the channel set up
        if (!powered) begin
            core_next.st = UBF_IDLE;
            core_next.ctrl[`UBF_CTRL_RX_TRIG_BIT] = 1'b0;
            core_next.ctrl[`UBF_CTRL_TX_TRIG_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            core_reg.st   <= UBF_IDLE;
            core_reg.ctrl <= `UBF_CTRL_RESET;
            core_reg.mode <= `UBF_MODE_RESET;
            core_reg.err  <= 1'b0;
            core_reg.irq  <= 1'b0;
        end else begin
            core_reg <= core_next;
        end
    end

    always_comb begin
        ctrl_rdata = core_reg.ctrl;
        ctrl_rdata[`UBF_CTRL_RX_TRIG_BIT] = 1'b0;
    end

    assign mode_rdata          = core_reg.mode;
    assign break_rx_error_flag = core_reg.err;
    assign break_busy          = core_reg.st != UBF_IDLE;
    assign done_irq            = core_reg.irq;
endmodule // ubf_break_ctrl

// ===== bench/ubf_chk_asserts.sv
// Port checker for the break-field control block
`timescale 1ns/100ps
module ubf_chk
    import ubf_pkg::*;
(
    input wire logic       clock,
    input wire logic       nrst,
    input ubf_wr_t         ctrl_wr,
    input ubf_wr_t         mode_wr,
    input wire logic [7:0] divisor,
    input ubf_evt_t        link_evt,
    input wire logic [7:0] ctrl_rdata,
    input wire logic [7:0] mode_rdata,
    input wire logic       break_rx_error_flag,
    input wire logic       break_busy,
    input wire logic       baud_tick,
    input wire logic       done_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_RD_ZERO: assert property (!ctrl_rdata[6])
        else $error("rx trigger reads one");
    AST_DONE_END: assert property (break_busy && link_evt.done && !ctrl_wr.wr
        |=> done_irq && !break_busy) else $error("no end on done");
    // A restart written in the completion cycle keeps the channel busy
    AST_IRQ_ONE: assert property (done_irq
        |-> ($past(ctrl_wr.wr) || !break_busy) ##1 !done_irq)
        else $error("irq not a single idle pulse");
    AST_ERR_HOLD: assert property (break_rx_error_flag && !ctrl_wr.wr
        |=> break_rx_error_flag) else $error("error flag dropped");
    AST_ERR_SRC: assert property ($rose(break_rx_error_flag)
        |-> $past(link_evt.error)) else $error("error flag without cause");
    AST_START: assert property (ctrl_wr.wr && ctrl_wr.data[6] && !mode_wr.wr
        && mode_rdata[7] && mode_rdata[5] |=> break_busy)
        else $error("trigger did not start");
    AST_REFUSE: assert property (ctrl_wr.wr && !mode_rdata[7] && !mode_wr.wr
        && !break_busy |=> !break_busy) else $error("start unpowered");
    AST_BAUD: assert property (baud_tick && divisor == 8'h03
        |=> !baud_tick [*7]) else $error("baud tick too early");
endmodule // ubf_chk
bind ubf_break_ctrl ubf_chk i_chk(.clock, .nrst, .ctrl_wr, .mode_wr,
    .divisor, .link_evt, .ctrl_rdata, .mode_rdata, .break_rx_error_flag,
    .break_busy, .baud_tick, .done_irq);

// ===== bench/ubf_far.sv
// Far-side framing model: completion and error pulses
`timescale 1ns/100ps
module ubf_far
    import ubf_pkg::*;
(
    input  wire logic clock,
    output ubf_evt_t  evt
);
    initial evt = '0;
    // Optional wait so slow answers are exercised too
    task automatic pulse(input logic err, input int n);
        repeat (n) @(posedge clock);
        evt <= err ? 2'b01 : 2'b10;
        @(posedge clock);
        evt <= '0;
    endtask
endmodule // ubf_far

// ===== bench/tb.sv
// Self-checking bench for the break-field control block
`timescale 1ns/100ps
module tb;
    import ubf_pkg::*;
    logic       clock = 0, nrst = 0, ef, bz, bt, irq;
    ubf_wr_t    cw = '0, mw = '0;
    logic [7:0] dv = 8'h03, rd, md;
    ubf_evt_t   ev;
    int         n_errors = 0, num_checks = 0, nt = 0;
    always #10 clock = ~clock;
    ubf_break_ctrl i_ubf_break_ctrl(.clock, .nrst, .ctrl_wr(cw), .mode_wr(mw),
        .divisor(dv), .link_evt(ev), .ctrl_rdata(rd), .mode_rdata(md),
        .break_rx_error_flag(ef), .break_busy(bz), .baud_tick(bt),
        .done_irq(irq));
    ubf_far i_ubf_far(.clock, .evt(ev));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic c, input logic [7:0] d);
        @(posedge clock);
        if (c) cw <= '{1'b1, d};
        else mw <= '{1'b1, d};
        @(posedge clock);
        cw.wr <= 1'b0;
        mw.wr <= 1'b0;
    endtask
    // Starts with a mode write, then a trigger write, then settles past the write edge
    task automatic go(input logic [7:0] m, input logic [7:0] t);
        wr(0, m);
        wr(1, t);
        @(negedge clock);
    endtask
    task automatic fin(input logic err);
        i_ubf_far.pulse(err, 2);
        @(negedge clock);
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        tally_and_finish;
    end
    task automatic t_rx_done;
        go(8'ha0, 8'h40);
        chk(bz, 1);
        chk(rd, 8'h00);
        chk(md, 8'ha0);
        fin(0);
        chk({irq, bz}, 2'b10);
    endtask
    // Error ends reception quietly and the flag sticks
    task automatic t_rx_error;
        go(8'ha0, 8'h40);
        fin(1);
        chk({irq, ef, bz}, 3'b010);
        repeat (5) @(negedge clock);
        chk({ef, bz}, 2'b10);
        wr(1, 8'h40);
        @(negedge clock);
        chk({ef, bz}, 2'b01);
    endtask
    // Rewrite in the completion cycle restarts the operation
    task automatic t_restart;
        fork
            i_ubf_far.pulse(0, 1);
            wr(1, 8'h40);
        join
        @(negedge clock);
        chk({irq, bz}, 2'b11);
        fin(0);
    endtask
    task automatic t_tx;
        go(8'hc0, 8'h20);
        chk(bz, 1);
        chk(rd, 8'h20);
        fin(0);
        chk(irq, 1);
        chk(rd, 8'h00);
    endtask
    task automatic t_baud;
        repeat (64) @(negedge clock) nt += bt;
        chk(nt, 8);
    endtask
    task automatic t_refuse;
        go(8'h00, 8'h40);
        chk(bz, 0);
    endtask
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        t_rx_done;
        t_rx_error;
        t_restart;
        t_tx;
        t_baud;
        t_refuse;
        tally_and_finish;
    end
endmodule // tb
